// File: flash_ctrl_pkg.sv
`default_nettype none
package flash_ctrl_pkg;

  // ==========================================================
  // organisation
  localparam int unsigned SECTOR_COUNT      = 8;
  localparam int unsigned SECTOR_BYTES      = 1024;
  localparam int unsigned PAGE_BYTES        = 64;
  localparam int unsigned ADDR_W            = 13;
  localparam int unsigned SECTOR_MSB        = 12;
  localparam int unsigned SECTOR_LSB        = 10;
  localparam int unsigned PAGE_LSB          = 6;
  localparam int unsigned MEM_BYTES         = SECTOR_COUNT * SECTOR_BYTES;
  localparam int unsigned LOADER_BYTES      = 512;
  localparam logic [12:0] LOADER_BASE       = 13'h1e00;
  localparam logic [7:0]  ERASED_BYTE       = 8'hff;
  localparam logic [7:0]  SECURED_READ_BYTE = 8'h00;

  // ==========================================================
  // timing: 2 ms at 10 MHz, longest time so rounded down
  localparam int unsigned OP_TIME_US  = 2000;
  localparam int unsigned CLK_MHZ     = 10;
  localparam int unsigned OP_CYCLES   = OP_TIME_US * CLK_MHZ;
  localparam int unsigned TIMER_W     = 15;

  // ==========================================================
  // crc
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  // ==========================================================
  // commands
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_LOAD_BUFFER,
    CMD_PROGRAM_PAGE,
    CMD_PROGRAM_BYTE,
    CMD_ERASE_BYTE,
    CMD_ERASE_PAGE,
    CMD_ERASE_SECTOR,
    CMD_ERASE_CHIP,
    CMD_SET_SECURITY,
    CMD_CLEAR_SECURITY,
    CMD_SET_BOOT_VECTOR,
    CMD_CRC_SECTOR,
    CMD_CRC_ALL
  } cmd_e;

  // the four special registers: control/status, data, address high/low
  typedef struct packed {
    cmd_e        cmd;
    logic [7:0]  data;
    logic [4:0]  addr_hi;
    logic [7:0]  addr_lo;
  } iap_req_s;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic        error;
    logic        crc_valid;
  } iap_status_s;

endpackage : flash_ctrl_pkg
`default_nettype wire

// File: flash_program_erase_control.sv
// Function
// - the array is eight 1 kB sectors, each cut into 64-byte pages.
// - one selected sector or one selected page can be erased alone.
// - chip erase clears the whole user array in one operation.
// - any single byte can be erased or programmed without touching its neighbours.
// - a 64-byte page buffer takes 1 to 64 bytes of one page and programs them at once.
// - every program or erase finishes inside 2 ms, timed internally.
// - a tripped flash supply monitor blocks every program and erase.
// - each sector has its own security setting.
// - code-space reads of secured sectors return no contents; unsecured ones read normally.
// - verification is a 32-bit CRC over one sector or the whole array, never readback.
// - as shipped the whole array, the top 512 bytes included, is blank (0xff); the boot vector resets to 1e00.
// - a configurable boot vector points the loader entry anywhere in flash.
// - the service offers erase/program of sectors, pages, security and configuration; the id is a fixed parameter.
// - operations are driven through control/status, data and two address registers.
`timescale 1ns/1ps
`default_nettype none

module flash_program_erase_control #(
  parameter int unsigned OP_CYCLES_P                = flash_ctrl_pkg::OP_CYCLES,
  parameter logic [12:0] BOOT_VECTOR_RESET          = flash_ctrl_pkg::LOADER_BASE,
  parameter logic [7:0]  DEVICE_ID                  = 8'h5a  // arbitrary value
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic                        req_valid,
  input  wire flash_ctrl_pkg::iap_req_s    req,
  output logic                             req_ready,
  output flash_ctrl_pkg::iap_status_s      status,
  output logic [31:0]                      crc_result,
  output logic [7:0]                       config_byte,
  output logic [7:0]                       device_id,
  input  wire logic                        flash_supply_monitor,
  input  wire logic                        code_read_valid,
  input  wire logic [12:0]                 code_read_addr,
  output logic [7:0]                       code_read_data,
  output logic [12:0]                      boot_vector,
  output logic [7:0]                       sector_secured
);

  // ==========================================================
  // storage
  logic [7:0]  mem_q [flash_ctrl_pkg::MEM_BYTES];
  logic [7:0]  page_buf_q [flash_ctrl_pkg::PAGE_BYTES];
  logic [flash_ctrl_pkg::PAGE_BYTES-1:0] buf_used_q;
  logic [7:0]  secure_q;
  logic [12:0] boot_vec_q;
  logic [7:0]  cfg_q;

  typedef enum logic [1:0] {ST_IDLE, ST_TIMED, ST_CRC} state_e;
  state_e state_q;
  flash_ctrl_pkg::cmd_e op_q;
  logic [12:0] addr_q;
  logic [7:0]  data_q;
  logic [flash_ctrl_pkg::TIMER_W-1:0] timer_q;
  logic [12:0] crc_idx_q;
  logic [12:0] crc_end_q;
  logic [31:0] crc_q;
  logic        busy_q, done_q, err_q, crc_ok_q;
  logic        mon_meta_q, mon_q;
  logic        init_q;
  logic [12:0] init_idx_q;
  logic [7:0]  rd_q;

  // ==========================================================
  // decode
  wire [12:0] req_addr    = {req.addr_hi, req.addr_lo};
  wire        is_modify   = req.cmd inside {flash_ctrl_pkg::CMD_PROGRAM_PAGE, flash_ctrl_pkg::CMD_PROGRAM_BYTE,
                                            flash_ctrl_pkg::CMD_ERASE_BYTE, flash_ctrl_pkg::CMD_ERASE_PAGE,
                                            flash_ctrl_pkg::CMD_ERASE_SECTOR, flash_ctrl_pkg::CMD_ERASE_CHIP,
                                            flash_ctrl_pkg::CMD_SET_SECURITY, flash_ctrl_pkg::CMD_CLEAR_SECURITY,
                                            flash_ctrl_pkg::CMD_SET_BOOT_VECTOR};
  wire        is_crc      = req.cmd inside {flash_ctrl_pkg::CMD_CRC_SECTOR, flash_ctrl_pkg::CMD_CRC_ALL};
  wire        idle        = (state_q == ST_IDLE) && init_q;
  wire        take        = req_valid && idle;
  wire        refuse_low  = take && is_modify && mon_q;
  wire        start_op    = take && is_modify && !mon_q;
  wire        start_crc   = take && is_crc;
  wire        timer_end   = (state_q == ST_TIMED) &&
                            (timer_q == flash_ctrl_pkg::TIMER_W'(OP_CYCLES_P - 1));
  wire        crc_last    = (state_q == ST_CRC) && (crc_idx_q == crc_end_q);
  wire [2:0]  rd_sector   = code_read_addr[flash_ctrl_pkg::SECTOR_MSB:flash_ctrl_pkg::SECTOR_LSB];
  wire [5:0]  buf_idx     = req.addr_lo[5:0];
  wire [6:0]  op_page     = addr_q[flash_ctrl_pkg::SECTOR_MSB:flash_ctrl_pkg::PAGE_LSB];
  wire [2:0]  op_sector   = addr_q[flash_ctrl_pkg::SECTOR_MSB:flash_ctrl_pkg::SECTOR_LSB];

  // crc of one byte, msb first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ flash_ctrl_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_byte

  wire [31:0] crc_next = crc_byte(crc_q, mem_q[crc_idx_q]);

  // ==========================================================
  // supply monitor comes from analog, so synchronise
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mon_meta_q <= 1'b1;
      mon_q      <= 1'b1;
    end else begin
      mon_meta_q <= flash_supply_monitor;
      mon_q      <= mon_meta_q;
    end
  end

  // ==========================================================
  // control
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      op_q       <= flash_ctrl_pkg::CMD_NONE;
      addr_q     <= '0;
      data_q     <= '0;
      timer_q    <= '0;
      crc_idx_q  <= '0;
      crc_end_q  <= '0;
      crc_q      <= flash_ctrl_pkg::CRC_INIT;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      err_q      <= 1'b0;
      crc_ok_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            done_q <= 1'b0;
            err_q  <= refuse_low;
          end
          if (start_op) begin
            state_q <= ST_TIMED;
            op_q    <= req.cmd;
            addr_q  <= req_addr;
            data_q  <= req.data;
            timer_q <= '0;
            busy_q  <= 1'b1;
          end else if (start_crc) begin
            state_q   <= ST_CRC;
            busy_q    <= 1'b1;
            crc_ok_q  <= 1'b0;
            crc_q     <= flash_ctrl_pkg::CRC_INIT;
            crc_idx_q <= (req.cmd == flash_ctrl_pkg::CMD_CRC_ALL) ? 13'h0000 : {req.addr_hi[4:2], 10'h000};
            crc_end_q <= (req.cmd == flash_ctrl_pkg::CMD_CRC_ALL) ? 13'h1fff : {req.addr_hi[4:2], 10'h3ff};
          end
        end
        ST_TIMED: begin
          timer_q <= timer_q + 1'b1;
          if (timer_end) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
          end
        end
        ST_CRC: begin
          crc_q     <= crc_next;
          crc_idx_q <= crc_idx_q + 1'b1;
          if (crc_last) begin
            state_q  <= ST_IDLE;
            busy_q   <= 1'b0;
            done_q   <= 1'b1;
            crc_ok_q <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // array update; written at the end of the timed window so a
  // reader never sees a half-done operation
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      init_q     <= 1'b0;
      init_idx_q <= '0;
      secure_q   <= '0;
      boot_vec_q <= BOOT_VECTOR_RESET;
      cfg_q      <= '0;
      buf_used_q <= '0;
    end else if (!init_q) begin
      // factory image: whole array blank-filled after every reset
      init_idx_q <= init_idx_q + 1'b1;
      mem_q[init_idx_q] <= flash_ctrl_pkg::ERASED_BYTE;
      if (init_idx_q == 13'h1fff) begin
        init_q <= 1'b1;
      end
    end else begin
      if (take && req.cmd == flash_ctrl_pkg::CMD_LOAD_BUFFER) begin
        page_buf_q[buf_idx] <= req.data;
        buf_used_q[buf_idx] <= 1'b1;
      end
      if (timer_end) begin
        case (op_q)
          flash_ctrl_pkg::CMD_PROGRAM_BYTE: mem_q[addr_q] <= data_q;
          flash_ctrl_pkg::CMD_ERASE_BYTE:   mem_q[addr_q] <= flash_ctrl_pkg::ERASED_BYTE;
          flash_ctrl_pkg::CMD_PROGRAM_PAGE: begin
            for (int i = 0; i < flash_ctrl_pkg::PAGE_BYTES; i++) begin
              if (buf_used_q[i]) begin
                mem_q[{op_page, 6'(i)}] <= page_buf_q[i];
              end
            end
            buf_used_q <= '0;
          end
          flash_ctrl_pkg::CMD_ERASE_PAGE: begin
            for (int i = 0; i < flash_ctrl_pkg::PAGE_BYTES; i++) begin
              mem_q[{op_page, 6'(i)}] <= flash_ctrl_pkg::ERASED_BYTE;
            end
          end
          flash_ctrl_pkg::CMD_ERASE_SECTOR: begin
            for (int i = 0; i < flash_ctrl_pkg::SECTOR_BYTES; i++) begin
              mem_q[{op_sector, 10'(i)}] <= flash_ctrl_pkg::ERASED_BYTE;
            end
          end
          flash_ctrl_pkg::CMD_ERASE_CHIP: begin
            for (int i = 0; i < flash_ctrl_pkg::MEM_BYTES; i++) begin
              mem_q[i] <= flash_ctrl_pkg::ERASED_BYTE;
            end
            secure_q <= '0;
          end
          flash_ctrl_pkg::CMD_SET_SECURITY:    secure_q[op_sector] <= 1'b1;
          flash_ctrl_pkg::CMD_CLEAR_SECURITY:  secure_q <= data_q;
          flash_ctrl_pkg::CMD_SET_BOOT_VECTOR: begin
            boot_vec_q <= addr_q;
            cfg_q      <= data_q;
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // code-space read port
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_q <= '0;
    end else if (code_read_valid) begin
      rd_q <= secure_q[rd_sector] ? flash_ctrl_pkg::SECURED_READ_BYTE : mem_q[code_read_addr];
    end
  end

  assign req_ready        = idle;
  assign status.busy      = busy_q;
  assign status.done      = done_q;
  assign status.error     = err_q;
  assign status.crc_valid = crc_ok_q;
  assign crc_result       = crc_q;
  assign config_byte      = cfg_q;
  assign device_id        = DEVICE_ID;
  assign code_read_data   = rd_q;
  assign boot_vector      = boot_vec_q;
  assign sector_secured   = secure_q;

endmodule : flash_program_erase_control

`default_nettype wire

// File: flash_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_checker (
  input wire logic                        sys_clk,
  input wire logic                        rst_n,
  input wire logic                        req_valid,
  input wire flash_ctrl_pkg::iap_req_s    req,
  input wire logic                        req_ready,
  input wire flash_ctrl_pkg::iap_status_s status,
  input wire logic                        flash_supply_monitor,
  input wire logic                        code_read_valid,
  input wire logic [12:0]                 code_read_addr,
  input wire logic [7:0]                  code_read_data,
  input wire logic [7:0]                  sector_secured
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // helpers: monitor must be steady 3 cycles to cover its 2-flop sync
  wire logic take    = req_valid && req_ready;
  wire logic mod_cmd = req.cmd inside {[flash_ctrl_pkg::CMD_PROGRAM_PAGE:flash_ctrl_pkg::CMD_ERASE_CHIP]};
  wire logic chip    = req.cmd == flash_ctrl_pkg::CMD_ERASE_CHIP;
  // ==========================================================
  // properties; op timing sized for an 8-cycle op parameter
  property p_ready_idle; status.busy |-> !req_ready; endproperty
  property p_op_time;
    (!flash_supply_monitor)[*3] ##0 (take && mod_cmd) |=> status.busy[*8] ##1 (!status.busy && status.done);
  endproperty
  property p_refuse;
    flash_supply_monitor[*3] ##0 (take && mod_cmd) |=> status.error && !status.busy && !status.done;
  endproperty
  property p_done_stands; status.done && !take |=> status.done; endproperty
  property p_error_stands; status.error && !take |=> status.error; endproperty
  property p_done_on_end; $fell(status.busy) |-> status.done && !status.error; endproperty
  property p_load_quiet;
    take && req.cmd == flash_ctrl_pkg::CMD_LOAD_BUFFER |=>
      req_ready && !status.busy && !status.done && !status.error && $stable(status.crc_valid);
  endproperty
  property p_secured_read;
    code_read_valid && sector_secured[code_read_addr[12:10]] |=> code_read_data == flash_ctrl_pkg::SECURED_READ_BYTE;
  endproperty
  property p_chip_unsecures;
    (!flash_supply_monitor)[*3] ##0 (take && chip) |-> ##[1:12] (status.done && sector_secured == 8'h00);
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("request taken while busy");
  a_op_time: assert property (p_op_time) else $error("operation time wrong");
  a_refuse: assert property (p_refuse) else $error("low supply request not refused");
  a_done_stands: assert property (p_done_stands) else $error("done dropped early");
  a_error_stands: assert property (p_error_stands) else $error("error dropped early");
  a_done_on_end: assert property (p_done_on_end) else $error("busy ended without done");
  a_load_quiet: assert property (p_load_quiet) else $error("buffer load changed status");
  a_secured_read: assert property (p_secured_read) else $error("secured byte readable");
  a_chip_unsecures: assert property (p_chip_unsecures) else $error("chip erase kept security");
  c_mod: cover property (take && mod_cmd);
  c_crc: cover property (status.crc_valid);
  c_err: cover property (status.error);
endmodule : flash_ctrl_checker
bind flash_program_erase_control flash_ctrl_checker chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .status(status),
  .flash_supply_monitor(flash_supply_monitor), .code_read_valid(code_read_valid),
  .code_read_addr(code_read_addr), .code_read_data(code_read_data), .sector_secured(sector_secured));
`default_nettype wire

// File: flash_fw_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_fw_model (
  input  wire logic                sys_clk,
  input  wire logic                req_ready,
  output logic                     req_valid,
  output flash_ctrl_pkg::iap_req_s req
);
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end
  // arguments set up before the strobe, all held until taken
  task automatic issue(input flash_ctrl_pkg::cmd_e c, input logic [12:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req       = '{cmd: c, data: d, addr_hi: a[12:8], addr_lo: a[7:0]};
    req_valid = 1'b1;
    while (!req_ready)
      @(negedge sys_clk);
    @(posedge sys_clk);
    @(negedge sys_clk);
    req_valid = 1'b0;
    req       = ~req; // released lines carry the inverse of the last request
  endtask : issue
endmodule : flash_fw_model
`default_nettype wire

// File: test_flash_program_erase_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_erase_control;
  localparam int unsigned OPC    = 8;
  localparam logic [7:0]  ID_VAL = 8'h3c; // arbitrary value
  logic                        sys_clk = 1'b0;
  logic                        rst_n = 1'b0;
  logic                        mon = 1'b0;
  logic                        code_read_valid = 1'b0;
  logic [12:0]                 code_read_addr = 13'h0000;
  logic                        req_valid;
  logic                        req_ready;
  flash_ctrl_pkg::iap_req_s    req;
  flash_ctrl_pkg::iap_status_s status;
  logic [31:0]                 crc_result;
  logic [7:0]                  config_byte;
  logic [7:0]                  device_id;
  logic [7:0]                  code_read_data;
  logic [7:0]                  sector_secured;
  logic [12:0]                 boot_vector;
  int                          err_total = 0;
  int                          check_count = 0;
  always #50 sys_clk = ~sys_clk;
  flash_fw_model fw_u (.sys_clk(sys_clk), .req_ready(req_ready), .req_valid(req_valid), .req(req));
  flash_program_erase_control #(.OP_CYCLES_P(OPC), .DEVICE_ID(ID_VAL)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .status(status), .crc_result(crc_result), .config_byte(config_byte), .device_id(device_id),
    .flash_supply_monitor(mon), .code_read_valid(code_read_valid), .code_read_addr(code_read_addr),
    .code_read_data(code_read_data), .boot_vector(boot_vector), .sector_secured(sector_secured));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input flash_ctrl_pkg::cmd_e c, input logic [12:0] a, input logic [7:0] d);
    int n;
    fw_u.issue(c, a, d);
    if (c == flash_ctrl_pkg::CMD_LOAD_BUFFER)
      return;
    repeat (2) @(negedge sys_clk);
    n = 0;
    while (!(status.done || status.error) && n < 9000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 9000)
      chk(32'h0, 32'h1);
  endtask : run
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    code_read_valid = 1'b1;
    code_read_addr  = a;
    @(negedge sys_clk);
    // strobe dropped a full cycle early: data must hold with valid low
    code_read_valid = 1'b0;
    @(negedge sys_clk);
    chk({24'h0, code_read_data}, {24'h0, exp});
  endtask : rd
  // msb-first, no final inversion; first byte differs, the rest erased
  function automatic logic [31:0] crc_of(input int n, input logic [7:0] first);
    logic [31:0] c;
    logic [7:0]  b;
    c = flash_ctrl_pkg::CRC_INIT;
    for (int k = 0; k < n; k++) begin
      b = (k == 0) ? first : 8'hff;
      for (int i = 7; i >= 0; i--)
        c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? flash_ctrl_pkg::CRC_POLY : 32'h0);
    end
    return c;
  endfunction : crc_of
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk({28'h0, status}, 32'h0);
    chk({19'h0, boot_vector}, 32'h1e00);
    chk({24'h0, sector_secured}, 32'h0);
    chk({24'h0, device_id}, {24'h0, ID_VAL});
    rd(13'h1fff, 8'hff);
    $display("t_reset finished");
  endtask : t_reset
  task automatic t_byte();
    run(flash_ctrl_pkg::CMD_PROGRAM_BYTE, 13'h0123, 8'ha5);
    rd(13'h0123, 8'ha5);
    rd(13'h0122, 8'hff);
    rd(13'h0124, 8'hff);
    run(flash_ctrl_pkg::CMD_ERASE_BYTE, 13'h0123, 8'h00);
    rd(13'h0123, 8'hff);
    $display("t_byte finished");
  endtask : t_byte
  task automatic t_page();
    run(flash_ctrl_pkg::CMD_LOAD_BUFFER, 13'h0040, 8'h11);
    run(flash_ctrl_pkg::CMD_LOAD_BUFFER, 13'h007f, 8'h22);
    run(flash_ctrl_pkg::CMD_PROGRAM_PAGE, 13'h0040, 8'h00);
    rd(13'h0040, 8'h11);
    rd(13'h007f, 8'h22);
    rd(13'h0041, 8'hff);
    run(flash_ctrl_pkg::CMD_PROGRAM_BYTE, 13'h0080, 8'h33);
    run(flash_ctrl_pkg::CMD_PROGRAM_BYTE, 13'h0400, 8'h44);
    run(flash_ctrl_pkg::CMD_ERASE_PAGE, 13'h0040, 8'h00);
    rd(13'h007f, 8'hff);
    rd(13'h0080, 8'h33);
    run(flash_ctrl_pkg::CMD_ERASE_SECTOR, 13'h0000, 8'h00);
    rd(13'h0080, 8'hff);
    rd(13'h0400, 8'h44);
    $display("t_page finished");
  endtask : t_page
  task automatic t_low();
    mon = 1'b1;
    repeat (3) @(negedge sys_clk);
    run(flash_ctrl_pkg::CMD_PROGRAM_BYTE, 13'h0200, 8'h5a);
    chk({31'h0, status.error}, 32'h1);
    run(flash_ctrl_pkg::CMD_ERASE_CHIP, 13'h0000, 8'h00);
    rd(13'h0200, 8'hff);
    rd(13'h0400, 8'h44);
    mon = 1'b0;
    repeat (3) @(negedge sys_clk);
    $display("t_low finished");
  endtask : t_low
  task automatic t_secure();
    run(flash_ctrl_pkg::CMD_PROGRAM_BYTE, 13'h0800, 8'h3c);
    run(flash_ctrl_pkg::CMD_CRC_SECTOR, 13'h0800, 8'h00);
    chk({31'h0, status.crc_valid}, 32'h1);
    chk(crc_result, crc_of(1024, 8'h3c));
    run(flash_ctrl_pkg::CMD_SET_SECURITY, 13'h0800, 8'h00);
    chk({24'h0, sector_secured}, 32'h04);
    rd(13'h0800, 8'h00);
    rd(13'h0400, 8'h44);
    run(flash_ctrl_pkg::CMD_CLEAR_SECURITY, 13'h0000, 8'h00);
    rd(13'h0800, 8'h3c);
    run(flash_ctrl_pkg::CMD_SET_SECURITY, 13'h0400, 8'h00);
    run(flash_ctrl_pkg::CMD_ERASE_CHIP, 13'h0000, 8'h00);
    chk({24'h0, sector_secured}, 32'h0);
    rd(13'h0400, 8'hff);
    run(flash_ctrl_pkg::CMD_CRC_ALL, 13'h0000, 8'h00);
    chk(crc_result, crc_of(8192, 8'hff));
    run(flash_ctrl_pkg::CMD_SET_BOOT_VECTOR, 13'h0345, 8'h81);
    chk({19'h0, boot_vector}, 32'h0345);
    chk({24'h0, config_byte}, 32'h81);
    $display("t_secure finished");
  endtask : t_secure
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    while (!req_ready)
      @(negedge sys_clk);
    t_reset();
    t_byte();
    t_page();
    t_low();
    t_secure();
    give_verdict();
  end
  initial begin
    #(100 * 60000);
    err_total++;
    give_verdict();
  end
endmodule : test_flash_program_erase_control
`default_nettype wire
